// file: shared/csx_pkg.sv
// counter set package: widths, moduli and reset values shared by the counter files
// assumes a single synchronous count clock domain
package csx_pkg;
  localparam int         DEC_W        = 4;
  localparam logic [3:0] DEC_LAST     = 4'h9;
  localparam logic [3:0] DEC_ZERO     = 4'h0;
  localparam int         RIP_W        = 4;
  localparam int         SYN_W        = 5;
  localparam int         UD_W         = 4;
  localparam int         RING_W       = 5;
  localparam int         TWR_W        = 5;
  localparam int         VM_W         = 8;
  localparam logic [3:0] VM_LO_LAST   = 4'h9;
  localparam logic [3:0] VM_HI_LAST   = 4'hf;
  localparam logic [7:0] VM_TERM      = 8'hf9;  // 159: high nibble 15, decade 9
  localparam logic [7:0] VM_START_DEF = 8'he2;  // 142 coded as 14*10+2, modulus 18
  localparam int         VM_MOD_MAX   = 160;
  localparam logic       BIT_ONE      = 1'b1;
  localparam logic       BIT_ZERO     = 1'b0;
endpackage

// file: rtl/csx_ring.sv
// ring and twisted-ring counters with self-correcting feedback
// assumes clear and the count clock are synchronous to clk
`timescale 1ns/1ps
module csx_ring
  import csx_pkg::*;
#(
  parameter int RW = RING_W,
  parameter int TW = TWR_W
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          clear,
  output logic [RW-1:0]      ringQ,
  output logic [TW-1:0]      twistQ
);
  // taps for twisted ring: floor(n/3)+1 last stages
  localparam int TAPS = TW / 3 + 1;

  logic [RW-1:0] ring_reg;
  logic [TW-1:0] twist_reg;
  wire           ringGatedBusy;
  wire           ringFeed;
  wire           twistFeed;

  ////////////////////////////////////////////////////////////////////////////
  // ring feeds zero while any gated stage (all but the last) holds a one
  assign ringGatedBusy = |ring_reg[RW-2:0];
  assign ringFeed      = ~ringGatedBusy;
  // twisted ring as a j-k first stage: j is the last inverted output, k is the
  // nor of the inverted taps, so a stray pattern drains back into the main loop
  assign twistFeed = (~twist_reg[TW-1] & ~twist_reg[0])
                     | (~(&twist_reg[TW-1 -: TAPS]) & twist_reg[0]);

  // both shift every clock; clear gives a defined start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ring_reg  <= '0;
      twist_reg <= '0;
    end else if (clear) begin
      ring_reg  <= '0;
      twist_reg <= '0;
    end else begin
      ring_reg  <= {ring_reg[RW-2:0], ringFeed};
      twist_reg <= {twist_reg[TW-2:0], twistFeed};
    end
  end

  assign ringQ  = ring_reg;
  assign twistQ = twist_reg;
endmodule

// file: rtl/csx_varmod.sv
// variable-modulus counter: decade cascaded with modulo-16, load at 159
// assumes startValue is held stable by the user, coded as tens-of-sixteen/decade
`timescale 1ns/1ps
module csx_varmod
  import csx_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            clear,
  input  wire logic [VM_W-1:0] startValue,
  output logic      [VM_W-1:0] countQ,
  output logic                 loadLatch
);
  logic [VM_W-1:0] cnt_reg;
  logic            latch_reg;
  wire             atTerm;
  wire             loCarry;
  wire [3:0]       loNext;
  wire [3:0]       hiNext;

  ////////////////////////////////////////////////////////////////////////////
  // last natural count detector and cascaded next state
  assign atTerm  = (cnt_reg == VM_TERM);
  assign loCarry = (cnt_reg[3:0] == VM_LO_LAST);
  assign loNext  = loCarry ? DEC_ZERO : cnt_reg[3:0] + 4'h1;
  assign hiNext  = loCarry ? cnt_reg[7:4] + 4'h1 : cnt_reg[7:4];

  // latch set by detection drives the load strobe; next edge clears it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg   <= '0;
      latch_reg <= BIT_ZERO;
    end else if (clear) begin
      cnt_reg   <= '0;
      latch_reg <= BIT_ZERO;
    end else begin
      latch_reg <= atTerm;
      cnt_reg   <= atTerm ? startValue : {hiNext, loNext};
    end
  end

  assign countQ    = cnt_reg;
  assign loadLatch = latch_reg;
endmodule

// file: rtl/csx_counters.sv
// top of the counter set: decade, ripple, divide-by-32, up/down, cascade, rings
// assumes all inputs synchronous to clk; ripple stages modelled as enabled toggles
`timescale 1ns/1ps
module csx_counters
  import csx_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              clear,
  input  wire logic              countIn,
  input  wire logic              countDown,
  input  wire logic              rippleDown,
  input  wire logic              presetLoad,
  input  wire logic [DEC_W-1:0]  presetValue,
  input  wire logic              storeStrobe,
  input  wire logic [VM_W-1:0]   startValue,
  output logic      [DEC_W-1:0]  decadeQ,
  output logic      [RIP_W-1:0]  rippleQ,
  output logic      [SYN_W-1:0]  div32Q,
  output logic      [UD_W-1:0]   upDownQ,
  output logic      [DEC_W-1:0]  cascadeQ,
  output logic      [DEC_W-1:0]  storeQ,
  output logic      [RING_W-1:0] ringQ,
  output logic      [TWR_W-1:0]  twistQ,
  output logic      [VM_W-1:0]   varModQ,
  output logic                   varModLoad
);
  logic [DEC_W-1:0] dec_reg;
  logic [RIP_W-1:0] rip_reg;
  logic [SYN_W-1:0] syn_reg;
  logic [UD_W-1:0]  ud_reg;
  logic [DEC_W-1:0] cas_reg;
  logic [DEC_W-1:0] store_reg;
  logic             cin_reg;
  logic             dir_reg;
  logic             rdir_reg;

  // decade successor, used by decade and cascade counters
  function automatic logic [DEC_W-1:0] decNext(input logic [DEC_W-1:0] v);
    decNext = (v == DEC_LAST) ? DEC_ZERO : v + 4'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // count clock rising edge; up/down stage clocks forced low while it is low
  wire countEdge = countIn & ~cin_reg;
  wire udClkGate = countIn & ~cin_reg;

  // ripple: each stage steps when previous stage output makes its leading edge
  wire [RIP_W-1:0] ripStep;
  assign ripStep[0] = countEdge;
  genvar g;
  generate
    for (g = 1; g < RIP_W; g++) begin : gRip
      // up: previous true output falls (inverted rises); down: true output rises
      assign ripStep[g] = ripStep[g-1] &
                          (rdir_reg ? ~rip_reg[g-1] : rip_reg[g-1]);
    end
  endgenerate

  // divide-by-32: toggle enables from and of lower stages, fifth with extra gate
  wire [SYN_W-1:0] synEn;
  assign synEn[0] = BIT_ONE;
  generate
    for (g = 1; g < SYN_W - 1; g++) begin : gSyn
      assign synEn[g] = &syn_reg[g-1:0];
    end
  endgenerate
  assign synEn[SYN_W-1] = ~(|(~syn_reg[SYN_W-2:0]));

  // up/down: identical cell, direction sampled only between count edges
  wire [UD_W-1:0] udEn;
  assign udEn[0] = udClkGate;
  generate
    for (g = 1; g < UD_W; g++) begin : gUd
      assign udEn[g] = udEn[g-1] & (dir_reg ? ~ud_reg[g-1] : ud_reg[g-1]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // input capture; direction registered away from the edge so a swap is clean
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cin_reg  <= BIT_ZERO;
      dir_reg  <= BIT_ZERO;
      rdir_reg <= BIT_ZERO;
    end else begin
      cin_reg  <= countIn;
      if (!countEdge) dir_reg  <= countDown;
      if (!countEdge) rdir_reg <= rippleDown;
    end
  end

  // counters proper
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dec_reg   <= '0;
      rip_reg   <= '0;
      syn_reg   <= '0;
      ud_reg    <= '0;
      cas_reg   <= '0;
      store_reg <= '0;
    end else if (clear) begin
      dec_reg   <= '0;
      rip_reg   <= '0;
      syn_reg   <= '0;
      ud_reg    <= '0;
      cas_reg   <= '0;
      store_reg <= '0;
    end else begin
      if (countEdge) dec_reg <= decNext(dec_reg);
      if (countEdge) syn_reg <= syn_reg ^ synEn;
      rip_reg <= rip_reg ^ ripStep;
      ud_reg  <= ud_reg ^ udEn;
      if (presetLoad) cas_reg <= presetValue;
      else if (countEdge) cas_reg <= decNext(cas_reg);
      if (storeStrobe) store_reg <= cas_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // self-correcting rings, shifted on every clk edge; the count edge is not used
  logic [RING_W-1:0] ringW;
  logic [TWR_W-1:0]  twistW;
  csx_ring #(.RW(RING_W), .TW(TWR_W)) uRing (
    .clk    (clk),
    .reset  (reset),
    .clear  (clear),
    .ringQ  (ringW),
    .twistQ (twistW)
  );

  // variable-modulus counter
  logic [VM_W-1:0] vmW;
  logic            vmLoadW;
  csx_varmod uVar (
    .clk        (clk),
    .reset      (reset),
    .clear      (clear),
    .startValue (startValue),
    .countQ     (vmW),
    .loadLatch  (vmLoadW)
  );

  // outputs all come from flip-flops
  assign decadeQ    = dec_reg;
  assign rippleQ    = rip_reg;
  assign div32Q     = syn_reg;
  assign upDownQ    = ud_reg;
  assign cascadeQ   = cas_reg;
  assign storeQ     = store_reg;
  assign ringQ      = ringW;
  assign twistQ     = twistW;
  assign varModQ    = vmW;
  assign varModLoad = vmLoadW;
endmodule

// file: sim/csx_counters_properties.sv
// checker for the counter set top: clear, varmod load, rings, quiet hold
// assumes one clk domain with async reset; bound to csx_counters below
`timescale 1ns/1ps
module csx_counters_properties
  import csx_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              clear,
  input wire logic              countIn,
  input wire logic [VM_W-1:0]   startValue,
  input wire logic [DEC_W-1:0]  decadeQ,
  input wire logic [RIP_W-1:0]  rippleQ,
  input wire logic [SYN_W-1:0]  div32Q,
  input wire logic [UD_W-1:0]   upDownQ,
  input wire logic [RING_W-1:0] ringQ,
  input wire logic [TWR_W-1:0]  twistQ,
  input wire logic [VM_W-1:0]   varModQ,
  input wire logic              varModLoad
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  // clear wins over counting in every variant checked here; cascade and store are not checked
  a_clear_zeros_all: assert property (
    clear |=> (decadeQ | rippleQ | upDownQ) == 4'h0 && div32Q == 5'h00
    && (ringQ | twistQ) == 5'h00 && varModQ == 8'h00 && !varModLoad)
    else $error("outputs not zero after clear");
  // varmod counts by one below the terminal count, loads start at it
  a_varmod_step: assert property (
    !clear && varModQ != VM_TERM |=> varModQ == (($past(varModQ[3:0]) == VM_LO_LAST)
    ? {$past(varModQ[7:4]) + 4'h1, 4'h0} : $past(varModQ) + 8'h01))
    else $error("varmod did not step by one");
  a_varmod_load: assert property (
    !clear && varModQ == VM_TERM |=> varModQ == $past(startValue) && varModLoad)
    else $error("varmod did not load start at terminal");
  a_load_one_cycle: assert property (
    varModLoad && !clear |=> !varModLoad)
    else $error("load latch not cleared");
  // empty ring must self start, a legal ring stays one-hot
  a_ring_starts: assert property (
    ringQ == 5'h00 && !clear |=> $onehot(ringQ))
    else $error("ring did not start");
  a_ring_legal: assert property (
    $onehot(ringQ) && !clear |=> $onehot(ringQ))
    else $error("ring left one-hot");
  a_twist_moves: assert property (
    !clear |=> twistQ != $past(twistQ))
    else $error("twisted ring stuck");
  // without a count event the gated counters must hold
  a_quiet_holds: assert property (
    (!countIn && !clear) [*3] |=> $stable(decadeQ) && $stable(upDownQ)
    && $stable(div32Q) && $stable(rippleQ))
    else $error("counter moved with no event");
  a_div32_step: assert property (
    !$stable(div32Q) && !$past(clear) |-> div32Q == $past(div32Q) + 5'h01)
    else $error("div32 bad step");
  a_decade_range: assert property (
    decadeQ <= DEC_LAST)
    else $error("decade out of range");
  c_load: cover property (varModLoad);
  c_twist_full: cover property (twistQ == 5'h1f);
  c_quiet: cover property ((!countIn && !clear) [*3]);
endmodule
bind csx_counters csx_counters_properties csx_counters_properties_inst (.clk, .reset,
  .clear, .countIn, .startValue, .decadeQ, .rippleQ, .div32Q, .upDownQ, .ringQ,
  .twistQ, .varModQ, .varModLoad);

// file: sim/tb.sv
// self-checking bench for the counter set top
// assumes inputs change at falling clk edges only
`timescale 1ns/1ps
module tb
  import csx_pkg::*;
;
  logic clk = 1'b0, reset = 1'b1, clear = 1'b0, countIn = 1'b0, countDown = 1'b0;
  logic rippleDown = 1'b0, presetLoad = 1'b0, storeStrobe = 1'b0, varModLoad;
  logic [3:0] presetValue = 4'h0, decadeQ, rippleQ, upDownQ, cascadeQ, storeQ;
  logic [4:0] div32Q, ringQ, twistQ;
  logic [7:0] startValue = 8'h00, varModQ;
  int         error_cnt = 0, cmp_count = 0;
  csx_counters csx_counters_inst (.clk, .reset, .clear, .countIn, .countDown,
    .rippleDown, .presetLoad, .presetValue, .storeStrobe, .startValue, .decadeQ,
    .rippleQ, .div32Q, .upDownQ, .cascadeQ, .storeQ, .ringQ, .twistQ, .varModQ,
    .varModLoad);
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // events need countIn low between them, two cycles apart
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge clk) countIn = 1'b1;
      @(negedge clk) countIn = 1'b0;
    end
    repeat (2) @(negedge clk);
  endtask
  task automatic do_clear();
    @(negedge clk) clear = 1'b1;
    @(negedge clk) clear = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_up();
    do_clear();
    pulse(33);
    check("decade", 8'(decadeQ), 8'h03);
    check("ripple", 8'(rippleQ), 8'h01);
    check("div32", 8'(div32Q), 8'h01);
    check("updown", 8'(upDownQ), 8'h01);
  endtask
  // down through zero, then turn round between events
  task automatic t_down();
    countDown = 1'b1;
    rippleDown = 1'b1;
    pulse(3);
    check("ripple down", 8'(rippleQ), 8'h0e);
    check("updown down", 8'(upDownQ), 8'h0e);
    countDown = 1'b0;
    pulse(1);
    check("updown turn", 8'(upDownQ), 8'h0f);
    do_clear();
    check("clear", 8'({decadeQ, upDownQ}), 8'h00);
  endtask
  // preset start, then a store taken while an event is counted
  task automatic t_cascade();
    presetValue = 4'h7;
    @(negedge clk) presetLoad = 1'b1;
    @(negedge clk) presetLoad = 1'b0;
    check("preset", 8'(cascadeQ), 8'h07);
    pulse(5);
    check("cascade wrap", 8'(cascadeQ), 8'h02);
    @(negedge clk) storeStrobe = 1'b1;
    countIn = 1'b1;
    @(negedge clk) storeStrobe = 1'b0;
    countIn = 1'b0;
    repeat (2) @(negedge clk);
    check("store", 8'(storeQ), 8'h02);
    check("still counting", 8'(cascadeQ), 8'h03);
  endtask
  task automatic t_varmod(input logic [7:0] sv);
    logic [7:0] e;
    logic       l;
    startValue = sv;
    do_clear();
    e = 8'h00;
    repeat (200) begin
      check("varmod count", varModQ, e);
      l = (e == VM_TERM);
      e = l ? sv : ((e[3:0] == VM_LO_LAST) ? {e[7:4] + 4'h1, 4'h0} : e + 8'h01);
      @(negedge clk);
      check("varmod load", 8'(varModLoad), 8'(l));
    end
  endtask
  // twisted ring ones count rises to five then falls: ten states
  task automatic t_rings();
    logic [4:0] first;
    int         k;
    do_clear();
    for (k = 0; k < 12; k++) begin
      check("twist ones", 8'($countones(twistQ)), 8'(k % 10 <= 5 ? k % 10 : 10 - k % 10));
      if (k == 1) first = ringQ;
      if (k > 0) check("ring onehot", 8'($onehot(ringQ)), 8'h01);
      if (k == 11) check("ring period", 8'(ringQ), 8'(first));
      @(negedge clk);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    t_up();
    t_down();
    t_cascade();
    t_varmod(VM_START_DEF);
    t_varmod(8'hf0);
    t_rings();
    summarize();
  end
  // run is about 530 cycles, so 5000 means a hang
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
endmodule
